// ==== rtl/dma_dest_pkg.sv ====
package dma_dest_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_DEST_CTRL_CH0 = 8'h00;
	localparam logic [7:0] OFS_DEST_CTRL_CH1 = 8'h04;
	localparam logic [7:0] OFS_SRC_CTRL_CH0  = 8'h08;
	localparam logic [7:0] OFS_SRC_CTRL_CH1  = 8'h0C;
	localparam logic [7:0] OFS_DEST_ADDR_CH0 = 8'h10;
	localparam logic [7:0] OFS_DEST_ADDR_CH1 = 8'h14;
	localparam logic [7:0] OFS_STATUS        = 8'h18;

	// destination control fields
	localparam int DCTL_ACT_LSB   = 0;
	localparam int DCTL_STEP_EN   = 5;
	localparam int DCTL_STEP_DIR  = 6;
	localparam logic [7:0] DCTL_RESET = 8'h00;

	// source control fields
	localparam int SCTL_SIZE      = 0;
	localparam int SCTL_BLOCK     = 1;
	localparam int SCTL_ENABLE    = 2;
	localparam logic [2:0] SCTL_RESET = 3'h0;

	// status fields, per channel i at bit STAT_STRIDE*i
	localparam int STAT_REQ       = 0;
	localparam int STAT_BURST     = 1;
	localparam int STAT_PEND      = 2;
	localparam int STAT_FIRST     = 3;
	localparam int STAT_PIN       = 4;
	localparam int STAT_STRIDE    = 8;

	// activation codes
	localparam logic [3:0] ACT_ADC      = 4'h1;
	localparam logic [3:0] ACT_PIN_EDGE = 4'h2;
	localparam logic [3:0] ACT_PIN_LVL  = 4'h3;
	localparam logic [3:0] ACT_SER0_TX  = 4'h4;
	localparam logic [3:0] ACT_SER0_RX  = 4'h5;
	localparam logic [3:0] ACT_SER1_TX  = 4'h6;
	localparam logic [3:0] ACT_SER1_RX  = 4'h7;
	localparam logic [3:0] ACT_AUTO_CS  = 4'h6;
	localparam logic [3:0] ACT_AUTO_BST = 4'h7;
	localparam logic [3:0] ACT_TMR_BASE = 4'h8;
	localparam logic [3:0] ACT_TMR_LAST = 4'hD;

	// address steps
	localparam int STEP_BYTE = 1;
	localparam int STEP_WORD = 2;

	localparam int NUM_CH  = 2;
	localparam int NUM_TMR = 6;

endpackage

// ==== rtl/dma_act_decode.sv ====
`timescale 1ns/10ps
module dma_act_decode
	import dma_dest_pkg::*;
(
	// selection
	input  wire logic [3:0]         act_code,
	input  wire logic               block_mode,
	// pin state
	input  wire logic               pin_low,
	input  wire logic               pin_fall,
	input  wire logic               first_xfer,
	// peripheral events
	input  wire logic               adc_end,
	input  wire logic [1:0]         ser_tx_done,
	input  wire logic [1:0]         ser_rx_done,
	input  wire logic [NUM_TMR-1:0] tmr_capa,
	// decoded activation
	output logic                    evt_hit,
	output logic                    lvl_req,
	output logic                    auto_req,
	output logic                    burst
);

	logic [3:0] tmr_idx;

	always_comb
	begin
		evt_hit  = 1'b0;
		lvl_req  = 1'b0;
		auto_req = 1'b0;
		burst    = 1'b0;
		tmr_idx  = act_code - ACT_TMR_BASE;
		// falling edge with first-transfer low level
		if (act_code == ACT_PIN_EDGE)
		begin
			evt_hit = pin_fall;
			lvl_req = first_xfer & pin_low;
		end
		else if (act_code == ACT_PIN_LVL)
			lvl_req = pin_low;
		else if (!block_mode)
		begin
			case (act_code)
				ACT_AUTO_CS:  auto_req = 1'b1;
				ACT_AUTO_BST:
				begin
					auto_req = 1'b1;
					burst    = 1'b1;
				end
				default: ;
			endcase
		end
		else
		begin
			case (act_code)
				ACT_ADC:     evt_hit = adc_end;
				ACT_SER0_TX: evt_hit = ser_tx_done[0];
				ACT_SER0_RX: evt_hit = ser_rx_done[0];
				ACT_SER1_TX: evt_hit = ser_tx_done[1];
				ACT_SER1_RX: evt_hit = ser_rx_done[1];
				default:
				begin
					if (act_code >= ACT_TMR_BASE && act_code <= ACT_TMR_LAST)
						evt_hit = tmr_capa[tmr_idx[2:0]];
				end
			endcase
		end
	end

endmodule

// ==== rtl/dma_dest_ctrl.sv ====
// Behaviour
// - Step field 00 or 10 leaves the destination address unchanged after a transfer.
// - Step field 01 adds 1 for byte or 2 for word transfers after each transfer.
// - Step field 11 subtracts 1 for byte or 2 for word transfers after each transfer.
// - Bits 3 to 0 pick the activation source, read through a table chosen by the mode.
// - Code 0010 starts on falling pin edges, the first transfer after enable on a low level.
// - Code 0011 starts whenever the request pin is low, which the requester drives low.
// - Normal mode code 0110 is cycle-steal auto-request and 0111 burst auto-request.
// - Block mode code 0001 starts on the converter conversion-end interrupt.
// - Block mode 0100/0101 are serial channel 0 tx/rx done, 0110/0111 serial channel 1.
// - Block mode 1000 to 1101 are timer channels 0 to 5 compare or capture A.
// - Transfer size bit 0 means byte and 1 means word, which sets the address step.
// - Block enable bit clear means normal mode and set means block mode.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module dma_dest_ctrl
	import dma_dest_pkg::*;
#(
	parameter int ADDR_W = 24
)
(
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               resetn,
	// register port
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [31:0]        reg_rdata,
	// external request pins, active low
	input  wire logic [NUM_CH-1:0]  ext_transfer_request_pin_n,
	// peripheral interrupt events
	input  wire logic               adc_end,
	input  wire logic [1:0]         ser_tx_done,
	input  wire logic [1:0]         ser_rx_done,
	input  wire logic [NUM_TMR-1:0] tmr_capa,
	// transfer engine
	input  wire logic [NUM_CH-1:0]  xfer_done,
	output logic      [NUM_CH-1:0]  xfer_req,
	output logic      [NUM_CH-1:0]  xfer_burst,
	output logic      [ADDR_W-1:0]  dest_addr_ch0,
	output logic      [ADDR_W-1:0]  dest_addr_ch1
);

	initial
	begin
		if (ADDR_W < 2 || ADDR_W > 32)
			$error("ADDR_W must lie in 2..32");
	end

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [NUM_CH-1:0][7:0]        dctl;
		logic [NUM_CH-1:0][2:0]        sctl;
		logic [NUM_CH-1:0][ADDR_W-1:0] daddr;
		logic [NUM_CH-1:0]             s1;
		logic [NUM_CH-1:0]             s2;
		logic [NUM_CH-1:0]             s3;
		logic [NUM_CH-1:0]             lvl;
		logic [NUM_CH-1:0]             en_prev;
		logic [NUM_CH-1:0]             first;
		logic [NUM_CH-1:0]             pend;
		logic [NUM_CH-1:0]             req;
		logic [NUM_CH-1:0]             burst;
		logic [31:0]                   rdata;
	} state_t;

	state_t st_q;
	state_t st_d;

	logic [NUM_CH-1:0] pin_fall;
	logic [NUM_CH-1:0] pin_low;
	logic [NUM_CH-1:0] evt_hit;
	logic [NUM_CH-1:0] lvl_req;
	logic [NUM_CH-1:0] auto_req;
	logic [NUM_CH-1:0] dec_burst;

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic [ADDR_W-1:0] step_addr(
		input logic [ADDR_W-1:0] addr,
		input logic              step_en,
		input logic              step_dir,
		input logic              word
	);
		logic [ADDR_W-1:0] step;
		step = word ? ADDR_W'(STEP_WORD) : ADDR_W'(STEP_BYTE);
		if (!step_en)
			step_addr = addr;
		else if (!step_dir)
			step_addr = addr + step;
		else
			step_addr = addr - step;
	endfunction

	function automatic logic [31:0] status_word(input state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		for (int i = 0; i < NUM_CH; i++)
		begin
			w[STAT_STRIDE*i+STAT_REQ]   = s.req[i];
			w[STAT_STRIDE*i+STAT_BURST] = s.burst[i];
			w[STAT_STRIDE*i+STAT_PEND]  = s.pend[i];
			w[STAT_STRIDE*i+STAT_FIRST] = s.first[i];
			w[STAT_STRIDE*i+STAT_PIN]   = s.lvl[i];
		end
		status_word = w;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// filtered pin state

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			pin_low[i]  = ~st_q.lvl[i];
			pin_fall[i] = st_q.lvl[i] & (st_q.s2[i] == st_q.s3[i]) & ~st_q.s3[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// activation decode per channel

	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_dec
		dma_act_decode u_dec (
			.act_code    (st_q.dctl[g][DCTL_ACT_LSB +: 4]),
			.block_mode  (st_q.sctl[g][SCTL_BLOCK]),
			.pin_low     (pin_low[g]),
			.pin_fall    (pin_fall[g]),
			.first_xfer  (st_q.first[g]),
			.adc_end     (adc_end),
			.ser_tx_done (ser_tx_done),
			.ser_rx_done (ser_rx_done),
			.tmr_capa    (tmr_capa),
			.evt_hit     (evt_hit[g]),
			.lvl_req     (lvl_req[g]),
			.auto_req    (auto_req[g]),
			.burst       (dec_burst[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		logic en;
		logic wr_dctl;
		logic wr_sctl;
		logic wr_addr;
		st_d = st_q;
		en      = 1'b0;
		wr_dctl = 1'b0;
		wr_sctl = 1'b0;
		wr_addr = 1'b0;

		// three-stage pin sampling, level taken when stages two and three agree
		st_d.s1 = ext_transfer_request_pin_n;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (st_q.s2[i] == st_q.s3[i])
				st_d.lvl[i] = st_q.s3[i];
		end

		for (int i = 0; i < NUM_CH; i++)
		begin
			en = st_q.sctl[i][SCTL_ENABLE];
			wr_dctl = reg_wr && reg_addr == (i == 0 ? OFS_DEST_CTRL_CH0 : OFS_DEST_CTRL_CH1);
			wr_sctl = reg_wr && reg_addr == (i == 0 ? OFS_SRC_CTRL_CH0 : OFS_SRC_CTRL_CH1);
			wr_addr = reg_wr && reg_addr == (i == 0 ? OFS_DEST_ADDR_CH0 : OFS_DEST_ADDR_CH1);

			if (wr_dctl)
				st_d.dctl[i] = reg_wdata[7:0];
			if (wr_sctl)
				st_d.sctl[i] = reg_wdata[2:0];

			if (wr_addr)
				st_d.daddr[i] = reg_wdata[ADDR_W-1:0];
			else if (xfer_done[i])
				st_d.daddr[i] = step_addr(st_q.daddr[i],
					st_q.dctl[i][DCTL_STEP_EN],
					st_q.dctl[i][DCTL_STEP_DIR],
					st_q.sctl[i][SCTL_SIZE]);

			st_d.en_prev[i] = en;
			if (!en)
				st_d.first[i] = 1'b0;
			else if (!st_q.en_prev[i])
				st_d.first[i] = 1'b1;
			else if (xfer_done[i])
				st_d.first[i] = 1'b0;

			// edge or event latch, set wins
			if (!en)
				st_d.pend[i] = 1'b0;
			else if (evt_hit[i])
				st_d.pend[i] = 1'b1;
			else if (xfer_done[i])
				st_d.pend[i] = 1'b0;

			st_d.req[i]   = en & (st_q.pend[i] | lvl_req[i] | auto_req[i]);
			st_d.burst[i] = en & dec_burst[i];
		end

		// read data, unmapped reads as zero
		st_d.rdata = 32'h0000_0000;
		if (reg_rd)
		begin
			unique case (reg_addr)
				OFS_DEST_CTRL_CH0: st_d.rdata = {24'h00_0000, st_q.dctl[0]};
				OFS_DEST_CTRL_CH1: st_d.rdata = {24'h00_0000, st_q.dctl[1]};
				OFS_SRC_CTRL_CH0:  st_d.rdata = {29'h0000_0000, st_q.sctl[0]};
				OFS_SRC_CTRL_CH1:  st_d.rdata = {29'h0000_0000, st_q.sctl[1]};
				OFS_DEST_ADDR_CH0: st_d.rdata = 32'(st_q.daddr[0]);
				OFS_DEST_ADDR_CH1: st_d.rdata = 32'(st_q.daddr[1]);
				OFS_STATUS:        st_d.rdata = status_word(st_q);
				default:           st_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q.dctl    <= {NUM_CH{DCTL_RESET}};
			st_q.sctl    <= {NUM_CH{SCTL_RESET}};
			st_q.daddr   <= '0;
			st_q.s1      <= '1;
			st_q.s2      <= '1;
			st_q.s3      <= '1;
			st_q.lvl     <= '1;
			st_q.en_prev <= '0;
			st_q.first   <= '0;
			st_q.pend    <= '0;
			st_q.req     <= '0;
			st_q.burst   <= '0;
			st_q.rdata   <= 32'h0000_0000;
		end
		else
			st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata     = st_q.rdata;
	assign xfer_req      = st_q.req;
	assign xfer_burst    = st_q.burst;
	assign dest_addr_ch0 = st_q.daddr[0];
	assign dest_addr_ch1 = st_q.daddr[1];

endmodule

// ==== dv/dma_dest_ctrl_assertions.sv ====
`timescale 1ns/10ps
module dma_dest_ctrl_assertions
	import dma_dest_pkg::*;
#(
	parameter int ADDR_W = 24
)
(
	// watched ports
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire logic [7:0]        reg_addr,
	input wire logic [31:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [31:0]       reg_rdata,
	input wire logic [NUM_CH-1:0] ext_transfer_request_pin_n,
	input wire logic              adc_end,
	input wire logic [1:0]        ser_tx_done,
	input wire logic [1:0]        ser_rx_done,
	input wire logic [5:0]        tmr_capa,
	input wire logic [NUM_CH-1:0] xfer_done,
	input wire logic [NUM_CH-1:0] xfer_req,
	input wire logic [NUM_CH-1:0] xfer_burst,
	input wire logic [ADDR_W-1:0] dest_addr_ch0
);
	logic [7:0]        dc_q;
	logic [2:0]        sc_q;
	logic              hit;
	logic [ADDR_W-1:0] stp;
	logic              on;
	logic              d0;
	logic              bad_n;
	logic              bad_b;
	////////////////////////////////////////////////////////////////
	// shadow of channel 0 control
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn)
		begin
			dc_q <= 8'h00;
			sc_q <= 3'h0;
		end
		else if (reg_wr)
		begin
			if (reg_addr == OFS_DEST_CTRL_CH0) dc_q <= reg_wdata[7:0];
			if (reg_addr == OFS_SRC_CTRL_CH0) sc_q <= reg_wdata[2:0];
		end
	always_comb
	begin
		case (dc_q[3:0])
			4'h1: hit = adc_end;
			4'h4: hit = ser_tx_done[0];
			4'h5: hit = ser_rx_done[0];
			4'h6: hit = ser_tx_done[1];
			4'h7: hit = ser_rx_done[1];
			4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD: hit = tmr_capa[dc_q[2:0]];
			default: hit = 1'b0;
		endcase
	end
	assign stp = sc_q[SCTL_SIZE] ? ADDR_W'(2) : ADDR_W'(1);
	assign on = sc_q[SCTL_ENABLE];
	assign d0 = xfer_done[0] && !(reg_wr && reg_addr == OFS_DEST_ADDR_CH0);
	assign bad_n = on && !sc_q[SCTL_BLOCK] && !(dc_q[3:0] inside {4'h2, 4'h3, 4'h6, 4'h7});
	assign bad_b = on && sc_q[SCTL_BLOCK] && (dc_q[3:0] inside {4'h0, 4'hE, 4'hF});
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	fixed_step_a: assert property (
		d0 && !dc_q[5] |=> $stable(dest_addr_ch0)) else $error("fixed address moved");
	inc_step_a: assert property (
		d0 && dc_q[6:5] == 2'b01 |=> dest_addr_ch0 == $past(dest_addr_ch0) + $past(stp))
		else $error("bad increment");
	dec_step_a: assert property (
		d0 && dc_q[6:5] == 2'b11 |=> dest_addr_ch0 == $past(dest_addr_ch0) - $past(stp))
		else $error("bad decrement");
	auto_burst_a: assert property (
		$rose(on && !sc_q[SCTL_BLOCK] && dc_q[3:0] == ACT_AUTO_BST) |-> ##[1:3] xfer_burst[0])
		else $error("no burst request");
	no_act_norm_a: assert property (
		bad_n [*3] |-> !xfer_req[0] && !xfer_burst[0]) else $error("request on bad code");
	no_act_blk_a: assert property (
		bad_b [*3] |-> !xfer_req[0]) else $error("request on bad block code");
	event_req_a: assert property (
		on && sc_q[SCTL_BLOCK] && hit |-> ##[1:2] xfer_req[0]) else $error("event missed");
	level_req_a: assert property (
		(on && dc_q[3:0] == ACT_PIN_LVL && !ext_transfer_request_pin_n[0]) [*8] |-> xfer_req[0])
		else $error("level request missed");
	rd_idle_a: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
	cover property (d0 && dc_q[6:5] == 2'b11);
	cover property (on && sc_q[SCTL_BLOCK] && hit);
	cover property ($rose(xfer_burst[0]));
endmodule
bind dma_dest_ctrl dma_dest_ctrl_assertions #(.ADDR_W(ADDR_W)) i_dma_dest_ctrl_assertions (.*);

// ==== dv/dma_far_model.sv ====
`timescale 1ns/10ps
module dma_far_model
	import dma_dest_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	// requester and engine
	input  wire logic [NUM_CH-1:0] want,
	input  wire logic [3:0]        lag,
	input  wire logic [NUM_CH-1:0] xfer_req,
	output logic      [NUM_CH-1:0] ext_transfer_request_pin_n,
	output logic      [NUM_CH-1:0] xfer_done
);
	logic [3:0] cnt_q [NUM_CH];
	assign ext_transfer_request_pin_n = ~want;
	// one done after lag+1 cycles of request
	always_ff @(posedge clk_sys or negedge resetn)
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (!resetn)
			begin
				cnt_q[i] <= 4'h0;
				xfer_done[i] <= 1'b0;
			end
			else
			begin
				xfer_done[i] <= xfer_req[i] && !xfer_done[i] && cnt_q[i] >= lag;
				cnt_q[i] <= (xfer_req[i] && cnt_q[i] < lag) ? cnt_q[i] + 4'h1 : 4'h0;
			end
		end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
	import dma_dest_pkg::*;
	logic        clk_sys, resetn, reg_wr, reg_rd, adc_end;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [1:0]  ext_transfer_request_pin_n, ser_tx_done, ser_rx_done, want;
	logic [1:0]  xfer_done, xfer_req, xfer_burst;
	logic [5:0]  tmr_capa;
	logic [10:0] ev;
	logic [3:0]  lag;
	logic [23:0] dest_addr_ch0, dest_addr_ch1, exp0, dstep;
	int          compares, miscompares, ndone, n;
	assign {tmr_capa, ser_rx_done, ser_tx_done, adc_end} = ev;
	dma_dest_ctrl i_dma_dest_ctrl (.*);
	dma_far_model i_dma_far_model (.*);
	////////////////////////////////////////////////////////////////
	function automatic logic [10:0] sel(input logic [3:0] c);
		case (c)
			4'h1: sel = 11'h001;
			4'h4: sel = 11'h002;
			4'h5: sel = 11'h008;
			4'h6: sel = 11'h004;
			4'h7: sel = 11'h010;
			4'h0, 4'hE, 4'hF: sel = 11'h000;
			default: sel = 11'h020 << (c - 4'h8);
		endcase
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk(reg_rdata, e);
	endtask
	task automatic report_and_stop;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
		if (xfer_done[0] === 1'b1)
		begin
			exp0 <= exp0 + dstep;
			ndone++;
		end
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		report_and_stop();
	end
	initial
	begin
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata, want, ev} = '0;
		{compares, miscompares, ndone, exp0, dstep} = '0;
		lag = 4'h3;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int a = 0; a < 32; a += 4) rchk(8'(a), (8'(a) == OFS_STATUS) ? 32'h0000_1010 : 32'h0);
		wr(OFS_DEST_CTRL_CH0, 32'hFF);
		rchk(OFS_DEST_CTRL_CH0, 32'hFF);
		wr(OFS_DEST_CTRL_CH1, 32'h90);
		rchk(OFS_DEST_CTRL_CH1, 32'h90);
		wr(OFS_DEST_ADDR_CH1, 32'h00AB_CDEF);
		rchk(OFS_DEST_ADDR_CH1, 32'h00AB_CDEF);
		chk(32'(dest_addr_ch1), 32'h00AB_CDEF);
		chk(32'({xfer_req[1], xfer_burst[1]}), 32'h0);
		$display("test registers done");
		for (int m = 0; m < 8; m++)
		begin
			dstep = m[0] ? (m[1] ? -24'(m[2] + 1) : 24'(m[2] + 1)) : 24'h0;
			wr(OFS_DEST_ADDR_CH0, 32'h100);
			exp0 = 24'h100;
			wr(OFS_DEST_CTRL_CH0, 32'(m[1:0]) << 5 | 32'(ACT_AUTO_CS));
			wr(OFS_SRC_CTRL_CH0, 32'h4 | 32'(m[2]));
			repeat (30) @(posedge clk_sys);
			chk(32'(xfer_burst[0]), 32'h0);
			wr(OFS_SRC_CTRL_CH0, 32'(m[2]));
			repeat (5) @(posedge clk_sys);
			rchk(OFS_DEST_ADDR_CH0, {8'h00, exp0});
		end
		wr(OFS_DEST_CTRL_CH0, 32'(ACT_AUTO_BST));
		wr(OFS_SRC_CTRL_CH0, 32'h4);
		repeat (4) @(posedge clk_sys);
		chk(32'(xfer_burst[0]), 32'h1);
		$display("test steps done");
		for (int c = 0; c < 16; c++)
		begin
			if (c inside {2, 3, 6, 7}) continue;
			wr(OFS_SRC_CTRL_CH0, 32'h0);
			wr(OFS_DEST_CTRL_CH0, 32'(c));
			wr(OFS_SRC_CTRL_CH0, 32'h4);
			ev <= 11'h7FF;
			repeat (6) @(posedge clk_sys);
			ev <= 11'h0;
			chk(32'(xfer_req[0]), 32'h0);
		end
		lag = 4'hF;
		for (int c = 0; c < 16; c++)
		begin
			if (c inside {2, 3}) continue;
			wr(OFS_SRC_CTRL_CH0, 32'h0);
			wr(OFS_DEST_CTRL_CH0, 32'(c));
			wr(OFS_SRC_CTRL_CH0, 32'h6);
			ev <= ~sel(4'(c));
			@(posedge clk_sys);
			ev <= 11'h0;
			repeat (4) @(posedge clk_sys);
			chk(32'(xfer_req[0]), 32'h0);
			ev <= sel(4'(c));
			@(posedge clk_sys);
			ev <= 11'h0;
			repeat (3) @(posedge clk_sys);
			chk(32'(xfer_req[0]), 32'(sel(4'(c)) != 0));
		end
		$display("test triggers done");
		lag = 4'h3;
		wr(OFS_SRC_CTRL_CH0, 32'h0);
		wr(OFS_DEST_CTRL_CH0, 32'(ACT_PIN_LVL));
		wr(OFS_SRC_CTRL_CH0, 32'h4);
		n = ndone;
		want <= 2'b01;
		repeat (20) @(posedge clk_sys);
		chk(32'(ndone - n >= 2), 32'h1);
		want <= 2'b00;
		repeat (8) @(posedge clk_sys);
		n = ndone;
		repeat (10) @(posedge clk_sys);
		chk(32'(ndone - n), 32'h0);
		wr(OFS_SRC_CTRL_CH0, 32'h0);
		wr(OFS_DEST_CTRL_CH0, 32'(ACT_PIN_EDGE));
		want <= 2'b01;
		repeat (6) @(posedge clk_sys);
		n = ndone;
		wr(OFS_SRC_CTRL_CH0, 32'h4);
		repeat (25) @(posedge clk_sys);
		chk(32'(ndone - n), 32'h1);
		want <= 2'b00;
		repeat (8) @(posedge clk_sys);
		want <= 2'b01;
		repeat (20) @(posedge clk_sys);
		chk(32'(ndone - n), 32'h2);
		$display("test pin done");
		report_and_stop();
	end
endmodule
